// [core/boot_select_defines.vh]
// Summary of operation
// [R1] flash splits into five blocks; blocks 0 and 1 are 8 kB each, 0000-3FFF
// [R2] blocks 2, 3 and 4 are 16 kB each, covering 4000-FFFF
// [R3] with boot rom enabled, fetches from FC00-FFFF come from the 1 kB rom
// [R4] with boot rom disabled, the top 1 kB is fetched from flash
// [R5] at reset release a zero status byte starts execution at 0000
// [R6] nonzero status byte: start address is boot vector high byte, low byte 00
// [R7] boot vector ships as FC, giving start address FC00
// [R8] erasing status byte or boot vector erases both; software rewrites both
// [R9] strobe low, external access high, latch pin high at release forces loader
// [R10] programmer should write status byte zero after loading flash
// [R11] flash changes must run from a block other than the one modified; code refuses only byte program and block erase
// [R12] external access select low disables internal memory; all fetches external
// [R13] flash read and written per byte; byte program takes about 20 us
// [R14] chip erase clears all flash; block erase clears one block only
// [R15] all self-programming operations enter through one common command port
// [R16] erase and program pulse timing is generated on chip
// [R17] start address and strap decision captured once at release, held
`ifndef BOOT_SELECT_DEFINES_VH
`define BOOT_SELECT_DEFINES_VH
`define OFS_CTRL 8'h00
`define OFS_CMD 8'h04
`define OFS_STAT 8'h08
`define OFS_ADDR 8'h0C
`define OFS_DATA 8'h10
`define OFS_RDATA 8'h14
`define OFS_NV 8'h18
`define OFS_BOOT 8'h1C
`define CTRL_ROM_EN_BIT 0
`define CTRL_RESET 1'b1
`define STAT_BUSY_BIT 0
`define STAT_REFUSED_BIT 1
`define STAT_DONE_BIT 2
`define OP_PROG_BYTE 3'h1
`define OP_READ_BYTE 3'h2
`define OP_BLOCK_ERASE 3'h3
`define OP_CHIP_ERASE 3'h4
`define OP_NV_ERASE 3'h5
`define OP_PROG_STATUS 3'h6
`define OP_PROG_VECTOR 3'h7
`define NV_STATUS_FACTORY 8'hFF
`define NV_VECTOR_FACTORY 8'hFC
`define NV_ERASED 8'hFF
`define ROM_BASE 16'hFC00
`define APP_START 16'h0000
`define START_LOW_BYTE 8'h00
`define CLK_PERIOD_PS 4000
`define PROG_TIME_US 20
`define ERASE_TIME_MS 3000
`endif

// [core/boot_select_program_memory_map.v]
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "boot_select_defines.vh"

module boot_select_program_memory_map #(
    parameter ADDR_W = 8,
    parameter [31:0] PROG_CYC =
        ((`PROG_TIME_US * 1000000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS,
    parameter [31:0] ERASE_CYC =
        `ERASE_TIME_MS * (1000000000 / `CLK_PERIOD_PS)
) (
    input wire ref_clk,
    input wire rst,
    input wire por,
    input wire [ADDR_W-1:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    input wire program_store_strobe_n,
    input wire external_access_select,
    input wire addr_latch_pin,
    output wire core_run,
    output wire [15:0] start_addr,
    input wire [15:0] fetch_addr,
    output wire fetch_ready,
    output reg [7:0] fetch_data,
    output wire fetch_ext,
    output wire [9:0] rom_addr,
    input wire [7:0] rom_rdata,
    input wire [7:0] ext_rdata,
    output wire [15:0] flash_addr,
    input wire [7:0] flash_rdata,
    output reg [7:0] flash_wdata,
    output reg flash_prog,
    output reg [4:0] flash_erase_mask
);

    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_READ = 4'b0010;
    localparam [3:0] ST_BUSY = 4'b0100;
    localparam [3:0] ST_DONE = 4'b1000;

    reg rom_en_q;
    reg rst_q;
    reg start_valid_q;
    reg strap_q;
    reg [15:0] start_q;
    reg [7:0] nv_status_q;
    reg [7:0] nv_vector_q;
    reg [3:0] state_q;
    reg [2:0] op_q;
    reg [31:0] cnt_q;
    reg [15:0] op_addr_q;
    reg [7:0] op_data_q;
    reg [7:0] rdata_q;
    reg refused_q;
    reg done_q;
    reg [15:0] reg_addr_q;
    reg [7:0] reg_data_q;

    wire wr_en;
    wire rd_en;
    wire busy;
    wire cmd_wr;
    wire cmd_ok;
    wire hit_rom;
    wire strap_now;
    wire [2:0] cmd_op;
    wire [2:0] exec_blk;
    wire [2:0] target_blk;
    wire blk_clash;
    wire op_done;
    reg addr_ok;

    // block number of an address: two 8 kB blocks then three 16 kB blocks
    function [2:0] blk_of;
        input [15:0] a;
        begin
            if (a[15:14] == 2'b00)
                blk_of = {2'b00, a[13]}; // [R1]
            else
                blk_of = {1'b0, a[15:14]} + 3'd1; // [R2]
        end
    endfunction

    // zero wait state slave: every access completes in its access phase
    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign cmd_wr = wr_en & (paddr == `OFS_CMD);
    assign cmd_op = pwdata[2:0];
    assign busy = (state_q != ST_IDLE);

    // application cannot program or block-erase the block it is executing from; chip erase is not checked
    assign exec_blk = blk_of(fetch_addr);
    assign target_blk = blk_of(reg_addr_q);
    assign blk_clash = (cmd_op == `OP_PROG_BYTE || cmd_op == `OP_BLOCK_ERASE) &&
                       external_access_select && !hit_rom &&
                       (exec_blk == target_blk); // [R11]
    assign cmd_ok = cmd_wr && !busy && (cmd_op != 3'h0) && !blk_clash; // [R15]

    // address decode for the bus answer
    always @*
    begin
        case (paddr)
            `OFS_CTRL, `OFS_CMD, `OFS_STAT, `OFS_ADDR,
            `OFS_DATA, `OFS_RDATA, `OFS_NV, `OFS_BOOT:
                addr_ok = 1'b1;
            default:
                addr_ok = 1'b0;
        endcase
    end

    // read mux; unmapped addresses read zero with an error
    always @*
    begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        if (psel & penable)
        begin
            pslverr = ~addr_ok | (cmd_wr & ~cmd_ok);
            if (rd_en)
            begin
                case (paddr)
                    `OFS_CTRL: prdata = {31'h0000_0000, rom_en_q};
                    `OFS_STAT: prdata = {29'h0000_0000, done_q, refused_q, busy};
                    `OFS_ADDR: prdata = {16'h0000, reg_addr_q};
                    `OFS_DATA: prdata = {24'h00_0000, reg_data_q};
                    `OFS_RDATA: prdata = {24'h00_0000, rdata_q};
                    `OFS_NV: prdata = {16'h0000, nv_vector_q, nv_status_q};
                    `OFS_BOOT: prdata = {15'h0000, strap_q, start_q};
                    default: prdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // software registers; sticky flags clear on write one, a new set wins
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            rom_en_q <= `CTRL_RESET;
            reg_addr_q <= 16'h0000;
            reg_data_q <= 8'h00;
            refused_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            if (wr_en && paddr == `OFS_CTRL)
                rom_en_q <= pwdata[`CTRL_ROM_EN_BIT];
            if (wr_en && paddr == `OFS_ADDR)
                reg_addr_q <= pwdata[15:0];
            if (wr_en && paddr == `OFS_DATA)
                reg_data_q <= pwdata[7:0];
            if (cmd_wr && !cmd_ok)
                refused_q <= 1'b1;
            else if (wr_en && paddr == `OFS_STAT && pwdata[`STAT_REFUSED_BIT])
                refused_q <= 1'b0;
            if (op_done)
                done_q <= 1'b1;
            else if (wr_en && paddr == `OFS_STAT && pwdata[`STAT_DONE_BIT])
                done_q <= 1'b0;
        end
    end

    // strap pattern that forces the loader
    assign strap_now = !program_store_strobe_n && external_access_select &&
                       addr_latch_pin; // [R9]

    // start address caught only at the release edge of reset; the core
    // is held until it is known, so no fetch sees a stale vector
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            rst_q <= 1'b1;
            start_valid_q <= 1'b0;
            strap_q <= 1'b0;
            start_q <= `APP_START;
        end
        else
        begin
            rst_q <= 1'b0;
            if (rst_q)
            begin
                start_valid_q <= 1'b1; // [R17]
                strap_q <= strap_now; // [R17]
                if (nv_status_q != 8'h00 || strap_now)
                    start_q <= {nv_vector_q, `START_LOW_BYTE}; // [R6] [R9]
                else
                    start_q <= `APP_START; // [R5]
            end
        end
    end

    assign core_run = start_valid_q;
    assign start_addr = start_q;

    // fetch decode: external, boot rom overlay, or flash
    assign fetch_ext = ~external_access_select; // [R12]
    assign hit_rom = rom_en_q && (fetch_addr >= `ROM_BASE); // [R3] [R4]
    assign rom_addr = fetch_addr[9:0]; // [R3]
    // flash port is shared; flash fetches stall while an operation runs
    assign fetch_ready = ~(busy & ~hit_rom & external_access_select);
    assign flash_addr = busy ? op_addr_q : fetch_addr;

    // fetch data registered one cycle after the address
    always @(posedge ref_clk)
    begin
        if (rst)
            fetch_data <= 8'h00;
        else if (!external_access_select)
            fetch_data <= ext_rdata; // [R12]
        else if (hit_rom)
            fetch_data <= rom_rdata; // [R3]
        else
            fetch_data <= flash_rdata; // [R4]
    end

    // nonvolatile bytes survive rst; por models a fresh part
    always @(posedge ref_clk)
    begin
        if (por)
        begin
            nv_status_q <= `NV_STATUS_FACTORY;
            nv_vector_q <= `NV_VECTOR_FACTORY; // [R7]
        end
        else if (op_done)
        begin
            case (op_q)
                `OP_NV_ERASE:
                begin
                    // the two bytes share one cell row, so both go together
                    nv_status_q <= `NV_ERASED; // [R8]
                    nv_vector_q <= `NV_ERASED; // [R8]
                end
                `OP_PROG_STATUS: nv_status_q <= op_data_q; // [R10]
                `OP_PROG_VECTOR: nv_vector_q <= op_data_q;
                default: nv_status_q <= nv_status_q;
            endcase
        end
    end

    assign op_done = (state_q == ST_DONE);

    // operation sequencer with on-chip pulse timing
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            op_q <= 3'h0;
            cnt_q <= 32'h0000_0000;
            op_addr_q <= 16'h0000;
            op_data_q <= 8'h00;
            rdata_q <= 8'h00;
            flash_wdata <= 8'h00;
            flash_prog <= 1'b0;
            flash_erase_mask <= 5'h00;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (cmd_ok)
                    begin
                        op_q <= cmd_op;
                        op_addr_q <= reg_addr_q;
                        op_data_q <= reg_data_q;
                        flash_wdata <= reg_data_q;
                        case (cmd_op)
                            `OP_READ_BYTE:
                                state_q <= ST_READ; // [R13]
                            `OP_PROG_BYTE:
                            begin
                                flash_prog <= 1'b1; // [R13]
                                cnt_q <= PROG_CYC - 32'd1; // [R16]
                                state_q <= ST_BUSY;
                            end
                            `OP_BLOCK_ERASE:
                            begin
                                flash_erase_mask <= 5'h01 << target_blk; // [R14]
                                cnt_q <= ERASE_CYC - 32'd1; // [R16]
                                state_q <= ST_BUSY;
                            end
                            `OP_CHIP_ERASE:
                            begin
                                flash_erase_mask <= 5'h1F; // [R14]
                                cnt_q <= ERASE_CYC - 32'd1;
                                state_q <= ST_BUSY;
                            end
                            `OP_NV_ERASE:
                            begin
                                cnt_q <= ERASE_CYC - 32'd1;
                                state_q <= ST_BUSY;
                            end
                            default:
                            begin
                                cnt_q <= PROG_CYC - 32'd1;
                                state_q <= ST_BUSY;
                            end
                        endcase
                    end
                end
                ST_READ:
                begin
                    rdata_q <= flash_rdata; // [R13]
                    state_q <= ST_DONE;
                end
                ST_BUSY:
                begin
                    if (cnt_q == 32'h0000_0000)
                    begin
                        flash_prog <= 1'b0;
                        flash_erase_mask <= 5'h00;
                        state_q <= ST_DONE;
                    end
                    else
                        cnt_q <= cnt_q - 32'd1; // [R16]
                end
                ST_DONE:
                    state_q <= ST_IDLE;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

endmodule
`default_nettype wire

// [sim/boot_map_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module boot_map_checker #(
    parameter [31:0] PROG_CYC = 32'd8
) (
    input wire ref_clk,
    input wire rst,
    input wire core_run,
    input wire [15:0] start_addr,
    input wire [15:0] fetch_addr,
    input wire fetch_ready,
    input wire [7:0] fetch_data,
    input wire fetch_ext,
    input wire external_access_select,
    input wire [9:0] rom_addr,
    input wire [7:0] ext_rdata,
    input wire [7:0] flash_rdata,
    input wire flash_prog,
    input wire [4:0] flash_erase_mask
);
    logic [31:0] prog_cnt_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // length of the current program pulse, cleared whenever it drops
    always @(posedge ref_clk)
        prog_cnt_q <= (rst || !flash_prog) ? 32'h0 : prog_cnt_q + 32'h1;
    ext_select_a: assert property (fetch_ext == !external_access_select)
        else $error("external fetch flag does not follow the select");
    rom_index_a: assert property (rom_addr == fetch_addr[9:0])
        else $error("rom index is not the low fetch bits");
    run_after_a: assert property (!rst |=> core_run)
        else $error("core not running after reset release");
    start_hold_a: assert property (core_run |=> $stable(start_addr))
        else $error("start address moved while running");
    start_low_a: assert property (core_run |-> start_addr[7:0] == 8'h00)
        else $error("start address low byte not zero");
    ext_fetch_a: assert property (!external_access_select |=> fetch_data == $past(ext_rdata))
        else $error("external fetch byte not passed");
    flash_fetch_a: assert property (external_access_select && fetch_ready
        && fetch_addr < 16'hFC00 |=> fetch_data == $past(flash_rdata))
        else $error("flash fetch byte not passed");
    erase_shape_a: assert property (flash_erase_mask != 5'h00 |->
        $onehot(flash_erase_mask) || flash_erase_mask == 5'h1F)
        else $error("erase covers neither one block nor all");
    prog_len_a: assert property ($fell(flash_prog) |-> prog_cnt_q == PROG_CYC)
        else $error("program pulse length wrong");
endmodule
`default_nettype wire

// [sim/fetch_side_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fetch_side_model (
    input wire ref_clk,
    input wire [15:0] flash_addr,
    input wire [4:0] flash_erase_mask,
    input wire [9:0] rom_addr,
    input wire [15:0] fetch_addr,
    output logic [7:0] flash_rdata,
    output logic [7:0] rom_rdata,
    output logic [7:0] ext_rdata
);
    logic [4:0] gone_q = 5'h00;
    logic [2:0] blk;
    // erased blocks stay blank for the run; programmed bytes are not stored
    always @(posedge ref_clk)
        gone_q <= gone_q | flash_erase_mask;
    // two 8 kB blocks below 4000, three 16 kB blocks above
    always_comb
    begin
        blk = flash_addr[15] ? (flash_addr[14] ? 3'd4 : 3'd3) :
            (flash_addr[14] ? 3'd2 : {2'b00, flash_addr[13]});
        flash_rdata = gone_q[blk] ? 8'hFF : flash_addr[7:0] ^ flash_addr[15:8] ^ 8'h3C;
        rom_rdata = rom_addr[7:0] ^ 8'h5A;
        ext_rdata = ~fetch_addr[7:0];
    end
endmodule
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic por = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic program_store_strobe_n = 1'b1, external_access_select = 1'b1, addr_latch_pin = 1'b0;
    logic [15:0] fetch_addr = 16'h0000;
    wire [31:0] prdata;
    wire pready, pslverr, core_run, fetch_ready, fetch_ext, flash_prog;
    wire [15:0] start_addr, flash_addr;
    wire [7:0] fetch_data, rom_rdata, ext_rdata, flash_rdata, flash_wdata;
    wire [9:0] rom_addr;
    wire [4:0] flash_erase_mask;
    int err_total = 0;
    int comparisons = 0;
    logic [31:0] rd;
    logic er;
    // short counts keep the run brief
    boot_select_program_memory_map #(.PROG_CYC(32'd8), .ERASE_CYC(32'd20)) dut (
        .ref_clk(ref_clk), .rst(rst), .por(por), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .program_store_strobe_n(program_store_strobe_n),
        .external_access_select(external_access_select), .addr_latch_pin(addr_latch_pin),
        .core_run(core_run), .start_addr(start_addr), .fetch_addr(fetch_addr),
        .fetch_ready(fetch_ready), .fetch_data(fetch_data), .fetch_ext(fetch_ext),
        .rom_addr(rom_addr), .rom_rdata(rom_rdata), .ext_rdata(ext_rdata),
        .flash_addr(flash_addr), .flash_rdata(flash_rdata), .flash_wdata(flash_wdata),
        .flash_prog(flash_prog), .flash_erase_mask(flash_erase_mask));
    fetch_side_model model (.ref_clk(ref_clk), .flash_addr(flash_addr),
        .flash_erase_mask(flash_erase_mask), .rom_addr(rom_addr), .fetch_addr(fetch_addr),
        .flash_rdata(flash_rdata), .rom_rdata(rom_rdata), .ext_rdata(ext_rdata));
    initial
        forever #2 ref_clk = ~ref_clk;
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3C;
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out;
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // one apb transfer; the edge first passed keeps psel from being set twice at once
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        // wait states end only at pready; the watchdog catches a slave that never answers
        while (pready !== 1'b1)
            @(posedge ref_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // start an operation, look at its pulses, then wait for done and clear it
    task automatic op(input logic [2:0] code, input logic [4:0] em, input logic ep);
        apb(1'b1, 8'h04, {29'h0, code});
        chk("command taken", 32'h0, {31'h0, er});
        #1;
        chk("erase mask", {27'h0, em}, {27'h0, flash_erase_mask});
        chk("program pulse", {31'h0, ep}, {31'h0, flash_prog});
        // flash port belongs to the operation, so a flash fetch must stall
        chk("flash fetch stalled", 32'h0, {31'h0, fetch_ready});
        rd = 32'h0;
        while (rd[2] !== 1'b1)
            apb(1'b0, 8'h08, 32'h0);
        apb(1'b1, 8'h08, 32'h4);
    endtask
    task automatic boot(input logic s, input logic [15:0] exp);
        @(posedge ref_clk);
        program_store_strobe_n <= ~s;
        addr_latch_pin <= s;
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk("start address", {16'h0, exp}, {16'h0, start_addr});
        apb(1'b0, 8'h1C, 32'h0);
        chk("boot register", {15'h0, s, exp}, rd);
    endtask
    task automatic fetch(input logic [15:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        fetch_addr <= a;
        repeat (2) @(posedge ref_clk);
        #1;
        chk("fetch byte", {24'h0, exp}, {24'h0, fetch_data});
    endtask
    logic [15:0] fa [6] = '{16'h0000, 16'h3FFF, 16'h4000, 16'hFBFF, 16'hFC00, 16'hFFFF};
    initial
    begin
        repeat (3) @(posedge ref_clk);
        por <= 1'b0;
        boot(1'b0, 16'hFC00);
        apb(1'b0, 8'h18, 32'h0);
        chk("nv bytes", 32'h0000FCFF, rd);
        apb(1'b1, 8'h10, 32'h00);
        op(3'h6, 5'h00, 1'b0);
        boot(1'b0, 16'h0000);
        boot(1'b1, 16'hFC00);
        @(posedge ref_clk) program_store_strobe_n <= 1'b1;
        apb(1'b0, 8'h1C, 32'h0);
        chk("strap held", 32'h0001FC00, rd);
        apb(1'b1, 8'h10, 32'h40);
        op(3'h7, 5'h00, 1'b0);
        apb(1'b1, 8'h10, 32'h05);
        op(3'h6, 5'h00, 1'b0);
        boot(1'b0, 16'h4000);
        op(3'h5, 5'h00, 1'b0);
        apb(1'b0, 8'h18, 32'h0);
        chk("nv erased", 32'h0000FFFF, rd);
        foreach (fa[i])
            fetch(fa[i], fa[i] >= 16'hFC00 ? fa[i][7:0] ^ 8'h5A : pat(fa[i]));
        apb(1'b1, 8'h00, 32'h0);
        fetch(16'hFFFF, pat(16'hFFFF));
        @(posedge ref_clk) external_access_select <= 1'b0;
        fetch(16'h1234, 8'hCB);
        chk("external flag", 32'h1, {31'h0, fetch_ext});
        @(posedge ref_clk) external_access_select <= 1'b1;
        apb(1'b1, 8'h0C, 32'h0123);
        apb(1'b1, 8'h10, 32'h5A);
        apb(1'b1, 8'h04, 32'h1);
        chk("same block refused", 32'h1, {31'h0, er});
        apb(1'b0, 8'h08, 32'h0);
        chk("refused flag", 32'h2, rd);
        apb(1'b1, 8'h08, 32'h2);
        apb(1'b0, 8'h08, 32'h0);
        chk("refused flag cleared", 32'h0, rd);
        apb(1'b1, 8'h04, 32'h0);
        chk("null command refused", 32'h1, {31'h0, er});
        fetch(16'h4000, pat(16'h4000));
        op(3'h1, 5'h00, 1'b1);
        chk("program byte", 32'h5A, {24'h0, flash_wdata});
        op(3'h2, 5'h00, 1'b0);
        apb(1'b0, 8'h14, 32'h0);
        chk("byte read", {24'h0, pat(16'h0123)}, rd);
        apb(1'b1, 8'h0C, 32'h8000);
        op(3'h3, 5'h08, 1'b0);
        fetch(16'h8000, 8'hFF);
        fetch(16'h4000, pat(16'h4000));
        op(3'h4, 5'h1F, 1'b0);
        fetch(16'h0000, 8'hFF);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        close_out;
    end
    // watchdog against a hung handshake
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        close_out;
    end
endmodule
bind boot_select_program_memory_map boot_map_checker #(.PROG_CYC(PROG_CYC)) chk_i (
    .ref_clk(ref_clk), .rst(rst), .core_run(core_run), .start_addr(start_addr),
    .fetch_addr(fetch_addr), .fetch_ready(fetch_ready), .fetch_data(fetch_data),
    .fetch_ext(fetch_ext), .external_access_select(external_access_select),
    .rom_addr(rom_addr), .ext_rdata(ext_rdata), .flash_rdata(flash_rdata),
    .flash_prog(flash_prog), .flash_erase_mask(flash_erase_mask));
`default_nettype wire
